/* hw/wdt_defs.vh */
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
// Register offsets (byte addresses)
`define WDT_OFS_CONTROL 32'h01d3_0000
`define WDT_OFS_RELOAD 32'h01d3_0004
`define WDT_OFS_COUNT 32'h01d3_0008
// Control field positions
`define WDT_CTL_PRE_HI 15
`define WDT_CTL_PRE_LO 8
`define WDT_CTL_EN_BIT 5
`define WDT_CTL_DIV_HI 4
`define WDT_CTL_DIV_LO 3
`define WDT_CTL_IRQ_BIT 2
`define WDT_CTL_RST_BIT 0
// Reset values
`define WDT_RST_CONTROL 16'h8021
`define WDT_RST_RELOAD 16'h8000
`define WDT_RST_COUNT 16'h8000
// Writable control bits; reserved bits 7:6 and 1 read zero
`define WDT_CTL_MASK 16'hff3d
// Reset pulse length in master-clock cycles
`define WDT_RST_CYCLES 8'h80
`endif

/* hw/wdt_prescaler.v */
`include "wdt_defs.vh"
// Produces one tick every (pre+1)*(16<<div_sel) clocks while run is high
module wdt_prescaler
(
    input wire clk_in,
    input wire rst_n_in,
    input wire run_in,
    input wire [7:0] pre_in,
    input wire [1:0] div_sel_in,
    output reg tick_out
);
    reg [7:0] pre_reg;
    reg [6:0] div_reg;
    reg [6:0] div_top;
    wire pre_wrap;

    always @*
    begin
        case (div_sel_in) // [RULE3]
            2'b00: div_top = 7'h0f;
            2'b01: div_top = 7'h1f;
            2'b10: div_top = 7'h3f;
            2'b11: div_top = 7'h7f;
            default: div_top = 7'h0f;
        endcase
    end

    assign pre_wrap = (pre_reg >= pre_in);

    // Prescale first, then divide the prescaled rate again [RULE1] [RULE4]
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pre_reg <= 8'h00;
            div_reg <= 7'h00;
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= 1'b0;
            if (run_in)
            begin
                if (pre_wrap)
                begin
                    pre_reg <= 8'h00;
                    if (div_reg >= div_top)
                    begin
                        div_reg <= 7'h00;
                        tick_out <= 1'b1;
                    end
                    else
                        div_reg <= div_reg + 7'h01;
                end
                else
                    pre_reg <= pre_reg + 8'h01;
            end
        end
    end
endmodule // wdt_prescaler

/* hw/wdt_reset_pulse.v */
`include "wdt_defs.vh"
// Stretches a one-cycle trigger into a reset of a fixed length
module wdt_reset_pulse
(
    input wire clk_in,
    input wire rst_n_in,
    input wire fire_in,
    output reg active_out
);
    reg [7:0] left_reg;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            left_reg <= 8'h00;
            active_out <= 1'b0;
        end
        else if (fire_in && !active_out)
        begin
            left_reg <= `WDT_RST_CYCLES - 8'h01; // [RULE7]
            active_out <= 1'b1;
        end
        else if (active_out)
        begin
            if (left_reg == 8'h00)
                active_out <= 1'b0;
            else
                left_reg <= left_reg - 8'h01;
        end
    end
endmodule // wdt_reset_pulse

/* hw/wdt_top.v */
// Operation
// [RULE1] Tick derived from master clock only
// [RULE2] Prescaler field bits 15:8, reset 0x80
// [RULE3] Division select bits 4:3: 16..128
// [RULE4] Tick period (pre+1)*division clocks
// [RULE5] Sixteen-bit counter, usable as interval timer
// [RULE6] Counter reaching zero is a time-out
// [RULE7] Reset output held 128 clocks
// [RULE8] Bit 5 enables counting, resets high
// [RULE9] Bit 2 enables interrupt, resets low
// [RULE10] Bit 0 enables reset output, resets high
// [RULE11] Software writes zero to reserved bits
// [RULE12] Control resets to 0x8021
// [RULE13] Software loads count before enabling
// [RULE14] Count resets 0x8000, later reloads
// [RULE15] Reload register sixteen bits, reset 0x8000
// [RULE16] Count register readable live, writable
// [RULE17] Debug acknowledge blocks reset output
// [RULE18] Interval use: interrupt on, reset off
// [RULE19] Decrement per tick while enabled
// [RULE20] Interrupt is one-cycle pulse when enabled
`include "wdt_defs.vh"
module wdt_top
(
    // Clock and reset
    input wire CLK_SYS_IN,
    input wire RESETN_IN,
    // Register port
    input wire [31:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    // Core status
    input wire CORE_DEBUG_ACKNOWLEDGE_IN,
    // Events
    output reg IRQ_OUT,
    output reg SYS_RESET_OUT
);
    // Reset synchroniser
    reg rst_sync1_reg;
    reg rst_sync2_reg;
    wire rst_n;

    // Register file
    reg [15:0] watchdog_control_reg;
    reg [15:0] watchdog_reload_value_reg;
    reg [15:0] watchdog_live_count_reg;
    reg [15:0] watchdog_control_next;
    reg [15:0] watchdog_reload_value_next;
    reg [15:0] watchdog_live_count_next;
    reg [31:0] rdata_next;

    // Address decode
    reg sel_ctl;
    reg sel_rld;
    reg sel_cnt;
    wire wr_ctl;
    wire wr_rld;
    wire wr_cnt;

    // Control fields
    wire [7:0] pre_val;
    wire [1:0] div_sel;
    wire run;
    wire irq_en;
    wire rst_en;

    // Time-out path
    wire tick;
    wire at_last;
    wire expire;
    wire fire;
    wire rst_active;
    reg timeout_reg;
    reg irq_next;

    // Release is re-timed so every flop leaves reset on the same edge
    always @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end
        else
        begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // Full 32-bit compare, so aliases of the three offsets stay unmapped
    always @*
    begin
        sel_ctl = 1'b0;
        sel_rld = 1'b0;
        sel_cnt = 1'b0;
        case (ADDR_IN)
            `WDT_OFS_CONTROL: sel_ctl = 1'b1;
            `WDT_OFS_RELOAD: sel_rld = 1'b1;
            `WDT_OFS_COUNT: sel_cnt = 1'b1;
            default:
            begin
                sel_ctl = 1'b0;
                sel_rld = 1'b0;
                sel_cnt = 1'b0;
            end
        endcase
    end

    // A write strobe on an unmapped address changes nothing
    assign wr_ctl = WR_IN && sel_ctl;
    assign wr_rld = WR_IN && sel_rld;
    assign wr_cnt = WR_IN && sel_cnt;

    // Field views of the control register
    assign pre_val =
        watchdog_control_reg[`WDT_CTL_PRE_HI:`WDT_CTL_PRE_LO]; // [RULE2]
    assign div_sel =
        watchdog_control_reg[`WDT_CTL_DIV_HI:`WDT_CTL_DIV_LO]; // [RULE3]
    assign run = watchdog_control_reg[`WDT_CTL_EN_BIT]; // [RULE8]
    assign irq_en = watchdog_control_reg[`WDT_CTL_IRQ_BIT]; // [RULE9]
    assign rst_en = watchdog_control_reg[`WDT_CTL_RST_BIT]; // [RULE10]

    // The divider phase freezes with the counter, so a pause stays exact
    wdt_prescaler i_wdt_prescaler
    (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .run_in(run),
        .pre_in(pre_val),
        .div_sel_in(div_sel),
        .tick_out(tick)
    );

    // A tick that finds the counter at one (or zero) ends the interval;
    // the counter reloads instead of resting at zero
    assign at_last = (watchdog_live_count_reg <= 16'h0001); // [RULE6]
    // A software write to the counter takes that cycle's tick
    assign expire = run && tick && at_last && !wr_cnt; // [RULE6]

    always @*
    begin
        watchdog_live_count_next = watchdog_live_count_reg;
        if (wr_cnt)
        begin
            watchdog_live_count_next = WDATA_IN[15:0]; // [RULE16]
        end
        else if (run && tick) // [RULE19]
        begin
            if (at_last)
            begin
                watchdog_live_count_next =
                    watchdog_reload_value_reg; // [RULE14]
            end
            else
            begin
                watchdog_live_count_next =
                    watchdog_live_count_reg - 16'h0001; // [RULE5]
            end
        end
    end

    // Reserved bits are forced to zero whatever software writes
    always @*
    begin
        watchdog_control_next = watchdog_control_reg;
        if (wr_ctl)
        begin
            watchdog_control_next = WDATA_IN[15:0] & `WDT_CTL_MASK;
        end
    end

    always @*
    begin
        watchdog_reload_value_next = watchdog_reload_value_reg;
        if (wr_rld)
        begin
            watchdog_reload_value_next = WDATA_IN[15:0]; // [RULE15]
        end
    end

    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_control_reg <= `WDT_RST_CONTROL; // [RULE12] [RULE2]
        end
        else
        begin
            watchdog_control_reg <= watchdog_control_next;
        end
    end

    // A new reload value is only used at the next time-out
    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_reload_value_reg <= `WDT_RST_RELOAD; // [RULE15]
        end
        else
        begin
            watchdog_reload_value_reg <= watchdog_reload_value_next;
        end
    end

    // The first interval runs from the reset value, not from the reload
    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_live_count_reg <= `WDT_RST_COUNT; // [RULE14]
        end
        else
        begin
            watchdog_live_count_reg <= watchdog_live_count_next;
        end
    end

    // Registering the event keeps the long compare off the output paths
    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timeout_reg <= 1'b0;
        end
        else
        begin
            timeout_reg <= expire; // [RULE6]
        end
    end

    // Debug hold suppresses the trigger, not a pulse already running
    assign fire = timeout_reg && rst_en && // [RULE10]
        !CORE_DEBUG_ACKNOWLEDGE_IN; // [RULE17]

    wdt_reset_pulse i_wdt_reset_pulse
    (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .fire_in(fire),
        .active_out(rst_active)
    );

    // Idle cycles and unmapped reads return zero
    always @*
    begin
        rdata_next = 32'h0000_0000;
        if (RD_IN)
        begin
            case ({sel_cnt, sel_rld, sel_ctl})
                3'b001: rdata_next = {16'h0000, watchdog_control_reg};
                3'b010: rdata_next = {16'h0000, watchdog_reload_value_reg};
                3'b100: // [RULE16]
                    rdata_next = {16'h0000, watchdog_live_count_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // One pulse per time-out; a masked event is simply lost
    always @*
    begin
        irq_next = timeout_reg && irq_en; // [RULE9] [RULE20]
    end

    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            RDATA_OUT <= 32'h0000_0000;
        end
        else
        begin
            RDATA_OUT <= rdata_next; // [RULE16]
        end
    end

    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            IRQ_OUT <= 1'b0;
        end
        else
        begin
            IRQ_OUT <= irq_next; // [RULE20]
        end
    end

    // A pulse still runs to its end if software clears the enable
    always @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            SYS_RESET_OUT <= 1'b0;
        end
        else
        begin
            SYS_RESET_OUT <= rst_active; // [RULE7]
        end
    end
endmodule // wdt_top

/* tb/wdt_top_asserts.sv */
`include "wdt_defs.vh"
module wdt_top_asserts
(
    input wire CLK_SYS_IN,
    input wire RESETN_IN,
    input wire [31:0] ADDR_IN,
    input wire RD_IN,
    input wire [31:0] RDATA_OUT,
    input wire CORE_DEBUG_ACKNOWLEDGE_IN,
    input wire IRQ_OUT,
    input wire SYS_RESET_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [8:0] len_reg;
    wire dbg = CORE_DEBUG_ACKNOWLEDGE_IN;
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESETN_IN);
    always @(posedge CLK_SYS_IN or negedge RESETN_IN)
        if (!RESETN_IN)
            len_reg <= 9'h000;
        else
            len_reg <= SYS_RESET_OUT ? len_reg + 9'h001 : 9'h000;
    property p_len; $fell(SYS_RESET_OUT) |-> len_reg == 9'h080; endproperty
    a_len: assert property (p_len) else $error("short reset");
    property p_max; len_reg <= 9'h080; endproperty
    a_max: assert property (p_max) else $error("long reset");
    // Ticks are at least 16 clocks apart
    property p_irq; IRQ_OUT |=> !IRQ_OUT [*8]; endproperty
    a_irq: assert property (p_irq) else $error("irq width");
    // The trigger edge lies two clocks before the output is seen high
    property p_dbg; $rose(SYS_RESET_OUT) |-> !$past(dbg, 2); endproperty
    a_dbg: assert property (p_dbg) else $error("reset in debug");
    property p_idle; !$past(RD_IN) |-> !RDATA_OUT; endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_hi; RD_IN |=> !RDATA_OUT[31:16]; endproperty
    a_hi: assert property (p_hi) else $error("rdata high");
    property p_unm; RD_IN && ADDR_IN[3:0] == 4'hc |=> !RDATA_OUT; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_rsv; RD_IN && ADDR_IN == `WDT_OFS_CONTROL |=>
        !RDATA_OUT[7:6] && !RDATA_OUT[1]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule // wdt_top_asserts
bind wdt_top wdt_top_asserts i_wdt_top_asserts (.CLK_SYS_IN, .RESETN_IN,
    .ADDR_IN, .RD_IN, .RDATA_OUT, .CORE_DEBUG_ACKNOWLEDGE_IN, .IRQ_OUT,
    .SYS_RESET_OUT);

/* tb/wdt_top_bench.sv */
`include "wdt_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module wdt_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [31:0] ctl = `WDT_OFS_CONTROL, rld = `WDT_OFS_RELOAD;
    localparam [31:0] cnt = `WDT_OFS_COUNT, bad = 32'h01d3_000c;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, dbg = 1'b0;
    logic [31:0] addr = 32'h0000_0000, wdata = 32'h0000_0000;
    wire [31:0] rdata;
    wire irq, srst;
    integer bad_count = 0, total_checks = 0, n, k, i;
    always #12.5 clk = ~clk;
    wdt_top i_wdt_top
    (
        .CLK_SYS_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq),
        .CORE_DEBUG_ACKNOWLEDGE_IN(dbg), .SYS_RESET_OUT(srst)
    );
    // Write d when w is set, otherwise read and expect d
    task bus(input logic w, input [31:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w)
            `CHK(rdata, d)
    endtask
    task wirq(output integer c);
        c = 0;
        do
            @(posedge clk) #1 c++;
        while (irq !== 1'b1 && c < 2000);
    endtask
    task t_regs;
        bus(0, ctl, 32'h0000_8021);
        bus(0, rld, 32'h0000_8000);
        bus(0, cnt, 32'h0000_8000);
        bus(1, ctl, 32'hffff_00df);
        bus(0, ctl, 32'h0000_001d);
        bus(1, cnt, 32'h0000_1234);
        bus(0, cnt, 32'h0000_1234);
        bus(1, bad, 32'h0000_ffff);
        bus(0, bad, 32'h0000_0000);
        bus(0, ctl, 32'h0000_001d);
    endtask
    // Time-out from a count of 1, then tally reset and irq cycles
    task t_fire(input logic d, input [31:0] c, input integer eh, ei);
        @(posedge clk);
        dbg <= d;
        bus(1, ctl, c & 32'hffff_ffdf);
        bus(1, cnt, 32'h0000_0001);
        bus(1, ctl, c);
        n = 0;
        k = 0;
        repeat (200)
        begin
            @(posedge clk) #1 n += (srst === 1'b1);
            k += (irq === 1'b1);
        end
        `CHK(n, eh)
        `CHK(k, ei)
    endtask
    // Only the second interval is exact: the first starts mid-phase
    task t_period;
        bus(1, rld, 32'h0000_0002);
        for (i = 0; i < 4; i++)
        begin
            bus(1, ctl, 32'h0000_0124 | (i << 3));
            bus(1, cnt, 32'h0000_0001);
            wirq(n);
            wirq(n);
            `CHK(n, 64 << i)
            bus(0, cnt, 32'h0000_0002);
            bus(1, ctl, 32'h0000_0104);
            `CHK(srst, 1'b0)
        end
        repeat (300) @(posedge clk);
        bus(0, cnt, 32'h0000_0002);
    endtask
    task give_verdict;
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs;
        t_fire(1'b1, 32'h0000_0025, 0, 1);
        t_fire(1'b0, 32'h0000_0021, 128, 0);
        t_period;
        give_verdict;
    end
    initial
    begin
        #300us bad_count++;
        give_verdict;
    end
endmodule // wdt_top_bench
